// file: logic/crc_checker_map.svh
// Named constants shared by the configuration checker and its test controller
// Assumes inclusion by bare name from files under logic/
`ifndef CRC_CHECKER_MAP_SVH
`define CRC_CHECKER_MAP_SVH

// Clock rate
`define CLK_PERIOD_NS 10
// Data and CRC widths
`define WORD_MSB 31
`define FCRC_MSB 15
// Frame layout: data words per frame, then one CRC word in the low half
`define FRAME_WORDS 4
`define FW_CW 3
`define FW_AW 2
`define NUM_FRAMES 16
`define FRAME_AW 4
`define CELL_WORDS 64
`define CELL_AW 6
`define BIT_AW 5
// Generators and seeds
`define CRC16_POLY 16'h1021
`define CRC16_INIT 16'hFFFF
`define CRC32_POLY 32'h04C11DB7
`define CRC32_INIT 32'hFFFFFFFF
// Test access instruction codes
`define INSTR_MSB 9
`define LOAD_CRC_REF_CODE 10'h015
`define IDLE_INSTR_CODE 10'h3FF
`define SHIFT_LAST 5'h1F
// Reconfiguration pulse: least width in ns and its cycle count
`define RECONFIG_PULSE_NS 100
`define RECONFIG_CYCLES ((`RECONFIG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CW 4
// Controller register word indices
`define ADDR_MSB 2
`define REG_CTRL 3'h0
`define REG_BAD_VALUE 3'h1
`define REG_SAVED 3'h2
`define REG_STATUS 3'h3
`define REG_IRQ_STATUS 3'h4
`define REG_IRQ_MASK 3'h5
// Control bits
`define CTRL_INJECT 0
`define CTRL_RESTORE 1
`define CTRL_RECONFIG 2
`define CTRL_AUTO 3
// Event bits, shared by status and mask
`define IRQ_MSB 2
`define IRQ_ERR_RISE 0
`define IRQ_OP_DONE 1
`define IRQ_CFG_FAIL 2

`endif

// file: logic/crc_checker_pkg.sv
// Types shared by the configuration checker and its test controller
// Assumes nothing from the map header; the state encodings are written here
package crc_checker_pkg;

  // Device life cycle
  typedef enum logic [1:0] {
    CFG_LOAD  = 2'b00,
    CFG_REF   = 2'b01,
    CFG_FAIL  = 2'b10,
    USER_MODE = 2'b11
  } cfg_state_t;

  // Test controller sequence
  typedef enum logic [1:0] {
    T_IDLE    = 2'b00,
    T_CAPTURE = 2'b01,
    T_SHIFT   = 2'b10,
    T_UPDATE  = 2'b11
  } test_state_t;

endpackage

// file: logic/crc_link_if.sv
// Link between the checking device and the test controller
// Assumes both ends run on the same core_clk; no clock travels here
`timescale 1ns/1ns
interface crc_link_if;
  logic reconfig_request_n;  // Low restarts configuration
  logic [9:0] instr;         // Selected test instruction
  logic dr_capture;          // Load shift register from reference
  logic dr_shift;            // Shift one bit per clock
  logic dr_update;           // Write shift register into reference
  logic tdi;                 // Serial data toward device
  logic tdo;                 // Serial data from device
  logic crc_error;           // High when last pass mismatched
  logic config_status_n;     // Low after a frame CRC mismatch

  modport device_end (
    input reconfig_request_n, instr, dr_capture, dr_shift, dr_update, tdi,
    output tdo, crc_error, config_status_n
  );
  modport test_end (
    output reconfig_request_n, instr, dr_capture, dr_shift, dr_update, tdi,
    input tdo, crc_error, config_status_n
  );
endinterface

// file: logic/config_memory_crc_checker.sv
// Device end: frame-checked configuration load, reference store and
// a user-mode scrubber that recomputes a 32-bit CRC over the cell array.
// Assumes the configuration stream and link are synchronous to core_clk.
// Function
// - Continuous check only when built in
// - Check each received frame against its CRC
// - Load stops at first bad frame
// - Keep bitstream reference in 32-bit store
// - User mode repeatedly recomputes and compares CRC
// - Checking runs until reconfiguration request low
// - Only the cell array is covered
// - One 32-bit CRC, IEEE 802 polynomial
// - Zero signature error low, else high
// - Instruction code connects reference store serially
// - Reference load honoured only in user mode
// - Controller injects fault with wrong reference
// - Controller restores the correct reference afterwards
// - Controller reads reference before overwriting it
// - System power cycles after injection test; here nothing power cycles, the controller writes the saved reference back
// - Monitor ignores error or pulses reconfiguration
// - Every frame carries a 16-bit CRC
// - Frame mismatch drives configuration status low
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "crc_checker_map.svh"
module config_memory_crc_checker
  import crc_checker_pkg::*;
#(
  parameter bit CHECK_ENABLE = 1'b1  // Build option for the scrubber
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration stream, one word per valid cycle
  input wire logic cfg_valid,
  input wire logic [`WORD_MSB:0] cfg_data,
  // Fault injection into one cell bit
  input wire logic single_event_upset,
  input wire logic [`CELL_AW-1:0] upset_addr,
  input wire logic [`BIT_AW-1:0] upset_bit,
  // Status toward the user
  output logic in_user_mode,
  output logic [`WORD_MSB:0] last_signature,
  // Link toward the test controller
  crc_link_if.device_end link
);

  // Frame CRC, MSB first over a 32-bit word
  function automatic logic [`FCRC_MSB:0] crc16_word(
    input logic [`FCRC_MSB:0] c,
    input logic [`WORD_MSB:0] d
  );
    logic [`FCRC_MSB:0] r;
    r = c;
    for (int i = `WORD_MSB; i >= 0; i--) begin
      r = {r[`FCRC_MSB-1:0], 1'b0} ^ ((r[`FCRC_MSB] ^ d[i]) ? `CRC16_POLY : '0);
    end
    return r;
  endfunction

  // Array CRC, MSB first, no reflection
  function automatic logic [`WORD_MSB:0] crc32_word(
    input logic [`WORD_MSB:0] c,
    input logic [`WORD_MSB:0] d
  );
    logic [`WORD_MSB:0] r;
    r = c;
    for (int i = `WORD_MSB; i >= 0; i--) begin
      r = {r[`WORD_MSB-1:0], 1'b0} ^ ((r[`WORD_MSB] ^ d[i]) ? `CRC32_POLY : '0);
    end
    return r;
  endfunction

  cfg_state_t state;                        // Life cycle state
  cfg_state_t next_state;                   // Its next value
  logic [`WORD_MSB:0] cell_array [0:`CELL_WORDS-1];  // Configuration cells
  logic [`FW_CW-1:0] word_cnt;              // Word within frame
  logic [`FRAME_AW-1:0] frame_cnt;          // Frame number
  logic [`FCRC_MSB:0] frame_crc;            // Running frame CRC
  logic [`WORD_MSB:0] crc_reference_store;  // Reference for user mode
  logic [`WORD_MSB:0] scan_crc;             // Running array CRC
  logic [`CELL_AW-1:0] scan_idx;            // Word being scanned
  logic [`WORD_MSB:0] shift_reg;            // Serial access register
  logic crc_err;                            // Error output flop
  logic status_n;                           // Config status flop

  // Restart on bus reset or on a reconfiguration request
  wire restart = ~rst_n | ~link.reconfig_request_n;
  wire in_load = (state == CFG_LOAD);
  wire take_word = cfg_valid & in_load;
  // Word after the data words carries the frame CRC
  wire crc_slot = (word_cnt == `FW_CW'(`FRAME_WORDS));
  wire last_frame = (frame_cnt == `FRAME_AW'(`NUM_FRAMES - 1));
  wire [`FCRC_MSB:0] next_frame_crc = crc16_word(frame_crc, cfg_data);
  // Compare received CRC with the one computed over the frame
  wire frame_bad = take_word & crc_slot & (cfg_data[`FCRC_MSB:0] != frame_crc);
  wire frame_good_last = take_word & crc_slot & ~frame_bad & last_frame;
  wire ref_word = cfg_valid & (state == CFG_REF);
  wire cell_wr = take_word & ~crc_slot;
  wire [`CELL_AW-1:0] cell_addr = {frame_cnt, word_cnt[`FW_AW-1:0]};
  wire user = (state == USER_MODE);
  // Serial access only for the right code and only in user mode
  wire jtag_sel = (link.instr == `LOAD_CRC_REF_CODE) & user;
  // Scrubber exists only when built in
  wire scan_run = CHECK_ENABLE & user;
  wire scan_last = (scan_idx == `CELL_AW'(`CELL_WORDS - 1));
  // Only cell_array words feed the CRC; memories and I/O are not here
  wire [`WORD_MSB:0] next_scan_crc = crc32_word(scan_crc, cell_array[scan_idx]);
  // Matching reference cancels to zero
  wire [`WORD_MSB:0] next_signature = next_scan_crc ^ crc_reference_store;
  wire upset_wr = single_event_upset & user;

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      CFG_LOAD: begin
        // Stop at first bad frame, or move on after the last good one
        if (frame_bad) begin
          next_state = CFG_FAIL;
        end else if (frame_good_last) begin
          next_state = CFG_REF;
        end
      end
      CFG_REF: begin
        if (cfg_valid) begin
          next_state = USER_MODE;
        end
      end
      CFG_FAIL: begin
        next_state = CFG_FAIL;  // Held until a reconfiguration request
      end
      USER_MODE: begin
        next_state = USER_MODE;
      end
      default: begin
        next_state = CFG_LOAD;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (restart) begin
      state <= CFG_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // Frame counters and running frame CRC
  always_ff @(posedge core_clk) begin
    if (restart) begin
      word_cnt <= '0;
      frame_cnt <= '0;
      frame_crc <= `CRC16_INIT;
    end else if (take_word && crc_slot) begin
      // New frame restarts the CRC
      word_cnt <= '0;
      frame_cnt <= frame_cnt + 1'b1;
      frame_crc <= `CRC16_INIT;
    end else if (take_word) begin
      word_cnt <= word_cnt + 1'b1;
      frame_crc <= next_frame_crc;
    end
  end

  // Cell array: loaded during configuration, upset only in user mode
  always_ff @(posedge core_clk) begin
    if (cell_wr) begin
      cell_array[cell_addr] <= cfg_data;
    end else if (upset_wr) begin
      cell_array[upset_addr] <= cell_array[upset_addr] ^ (32'h00000001 << upset_bit);
    end
  end

  // Reference store: bitstream word at the end of load, or serial update
  always_ff @(posedge core_clk) begin
    if (restart) begin
      crc_reference_store <= '0;
    end else if (ref_word) begin
      crc_reference_store <= cfg_data;
    end else if (jtag_sel && link.dr_update) begin
      crc_reference_store <= shift_reg;
    end
  end

  // Serial access register; LSB goes out first
  always_ff @(posedge core_clk) begin
    if (restart) begin
      shift_reg <= '0;
    end else if (jtag_sel && link.dr_capture) begin
      shift_reg <= crc_reference_store;
    end else if (jtag_sel && link.dr_shift) begin
      shift_reg <= {link.tdi, shift_reg[`WORD_MSB:1]};
    end
  end

  // Scrubber: one word per clock, result at the end of each pass
  always_ff @(posedge core_clk) begin
    if (restart) begin
      scan_idx <= '0;
      scan_crc <= `CRC32_INIT;
      crc_err <= 1'b0;
      last_signature <= '0;
    end else if (scan_run && scan_last) begin
      // Error holds its value for a whole pass; no gap between passes
      scan_idx <= '0;
      scan_crc <= `CRC32_INIT;
      last_signature <= next_signature;
      crc_err <= |next_signature;
    end else if (scan_run) begin
      scan_idx <= scan_idx + 1'b1;
      scan_crc <= next_scan_crc;
    end
  end

  // Configuration status goes low on a frame mismatch and stays low
  always_ff @(posedge core_clk) begin
    if (restart) begin
      status_n <= 1'b1;
    end else if (frame_bad) begin
      status_n <= 1'b0;
    end
  end

  // Outputs
  assign in_user_mode = user;
  assign link.tdo = shift_reg[0];
  assign link.crc_error = crc_err;
  assign link.config_status_n = status_n;

endmodule

// file: logic/crc_test_controller.sv
// Far end: test controller and error monitor, ordered over Avalon-MM.
// Assumes the device end shares core_clk and sits on the same link.
`timescale 1ns/1ns
`include "crc_checker_map.svh"
module crc_test_controller
  import crc_checker_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave, word addressed
  input wire logic [`ADDR_MSB:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`WORD_MSB:0] avs_writedata,
  output logic [`WORD_MSB:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Link toward the device
  crc_link_if.test_end link
);

  test_state_t state;                 // Sequence state
  logic is_inject;                    // Current run keeps tdo bits
  logic [`BIT_AW-1:0] bit_cnt;        // Bits shifted so far
  logic [`WORD_MSB:0] sh_out;         // Value going out on tdi
  logic [`WORD_MSB:0] saved;          // Reference read back
  logic saved_valid;                  // Saved holds a read value
  logic [`WORD_MSB:0] bad_value;      // Value to inject
  logic auto_reconfig;                // Pulse on every error rise
  logic [`PULSE_CW-1:0] pulse_cnt;    // Reconfiguration pulse left
  logic [`IRQ_MSB:0] irq_status;      // Sticky events
  logic [`IRQ_MSB:0] irq_mask;        // Event enables
  logic err_prev;                     // Error level last cycle
  logic status_prev;                  // Status level last cycle
  logic wait_done;                    // One wait state served

  // Bus decode: one wait state, access acts on the second cycle
  wire bus_req = avs_read | avs_write;
  wire wr_go = avs_write & wait_done;
  wire wr_ctrl = wr_go & (avs_address == `REG_CTRL);
  wire wr_bad = wr_go & (avs_address == `REG_BAD_VALUE);
  wire wr_irq = wr_go & (avs_address == `REG_IRQ_STATUS);
  wire wr_mask = wr_go & (avs_address == `REG_IRQ_MASK);
  wire idle = (state == T_IDLE);
  // Inject wins when both are asked in one write
  wire start_inj = wr_ctrl & avs_writedata[`CTRL_INJECT] & idle;
  wire start_rst = wr_ctrl & avs_writedata[`CTRL_RESTORE] & idle & ~start_inj;
  wire last_bit = (bit_cnt == `SHIFT_LAST);
  wire pulse_active = (pulse_cnt != '0);
  wire busy = ~idle | pulse_active;
  // Events
  wire err_rise = link.crc_error & ~err_prev;
  wire op_done = (state == T_UPDATE);
  wire cfg_fail = ~link.config_status_n & status_prev;
  wire [`IRQ_MSB:0] irq_event = {cfg_fail, op_done, err_rise};
  wire [`IRQ_MSB:0] irq_clr = wr_irq ? avs_writedata[`IRQ_MSB:0] : '0;
  // Monitor either ignores the error or pulses reconfiguration
  wire pulse_go = (wr_ctrl & avs_writedata[`CTRL_RECONFIG]) | (auto_reconfig & err_rise);
  wire [`WORD_MSB:0] status_word = {28'h0000000, saved_valid, link.config_status_n,
                                    link.crc_error, busy};
  // Read selection; unmapped words read zero
  wire [`WORD_MSB:0] read_mux =
    (avs_address == `REG_CTRL) ? {28'h0000000, auto_reconfig, 3'h0} :
    (avs_address == `REG_BAD_VALUE) ? bad_value :
    (avs_address == `REG_SAVED) ? saved :
    (avs_address == `REG_STATUS) ? status_word :
    (avs_address == `REG_IRQ_STATUS) ? {29'h00000000, irq_status} :
    (avs_address == `REG_IRQ_MASK) ? {29'h00000000, irq_mask} : '0;

  // Wait state and registered read data
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_done <= 1'b0;
      avs_readdata <= '0;
    end else begin
      wait_done <= bus_req & ~wait_done;
      if (avs_read && !wait_done) begin
        avs_readdata <= read_mux;
      end
    end
  end

  // Software settings
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bad_value <= '0;
      auto_reconfig <= 1'b0;
      irq_mask <= '0;
    end else begin
      if (wr_bad) begin
        bad_value <= avs_writedata;
      end
      if (wr_ctrl) begin
        auto_reconfig <= avs_writedata[`CTRL_AUTO];
      end
      if (wr_mask) begin
        irq_mask <= avs_writedata[`IRQ_MSB:0];
      end
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status <= '0;
      err_prev <= 1'b0;
      status_prev <= 1'b1;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_event;
      err_prev <= link.crc_error;
      status_prev <= link.config_status_n;
    end
  end

  // Shift sequence: capture, 32 shifts, update
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= T_IDLE;
      is_inject <= 1'b0;
      bit_cnt <= '0;
      sh_out <= '0;
    end else begin
      case (state)
        T_IDLE: begin
          if (start_inj) begin
            // Bad value goes in while the good one comes out
            state <= T_CAPTURE;
            is_inject <= 1'b1;
            sh_out <= bad_value;
          end else if (start_rst) begin
            state <= T_CAPTURE;
            is_inject <= 1'b0;
            sh_out <= saved;
          end
        end
        T_CAPTURE: begin
          state <= T_SHIFT;
          bit_cnt <= '0;
        end
        T_SHIFT: begin
          sh_out <= {1'b0, sh_out[`WORD_MSB:1]};
          bit_cnt <= bit_cnt + 1'b1;
          if (last_bit) begin
            state <= T_UPDATE;
          end
        end
        T_UPDATE: begin
          state <= T_IDLE;
        end
        default: begin
          state <= T_IDLE;
        end
      endcase
    end
  end

  // Correct reference is kept before the bad one takes effect
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      saved <= '0;
      saved_valid <= 1'b0;
    end else if (state == T_SHIFT && is_inject) begin
      saved <= {link.tdo, saved[`WORD_MSB:1]};
      saved_valid <= last_bit;
    end
  end

  // Reconfiguration pulse of least width
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pulse_cnt <= '0;
    end else if (pulse_go && !pulse_active) begin
      pulse_cnt <= `PULSE_CW'(`RECONFIG_CYCLES);
    end else if (pulse_active) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  // Outputs
  assign avs_waitrequest = bus_req & ~wait_done;
  assign irq = |(irq_status & irq_mask);
  assign link.reconfig_request_n = ~pulse_active;
  assign link.instr = idle ? `IDLE_INSTR_CODE : `LOAD_CRC_REF_CODE;
  assign link.dr_capture = (state == T_CAPTURE);
  assign link.dr_shift = (state == T_SHIFT);
  assign link.dr_update = (state == T_UPDATE);
  assign link.tdi = sh_out[0];

endmodule

// file: tb/crc_link_assertions.sv
// Checker for the serial link between the checking device and its test controller
// Assumes the bench top instantiates it beside the link interface, one clock
`timescale 1ns/1ns
module crc_link_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic reconfig_request_n,
  input wire logic [9:0] instr,
  input wire logic dr_capture,
  input wire logic dr_shift,
  input wire logic dr_update,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic crc_error,
  input wire logic config_status_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [5:0] shift_cnt;  // Consecutive shift cycles so far
  logic seq_on;           // Any sequence strobe up
  assign seq_on = dr_capture | dr_shift | dr_update;

  // Count shift cycles; a one-bit slip in the sequencer shows up here
  always_ff @(posedge core_clk) begin
    if (!rst_n || !dr_shift) begin
      shift_cnt <= 6'h00;
    end else begin
      shift_cnt <= shift_cnt + 6'h01;
    end
  end

  instr_code_a: assert property (seq_on |-> instr == 10'h015)
    else $error("instruction code wrong during sequence");
  idle_code_a: assert property (!seq_on |-> instr == 10'h3FF)
    else $error("instruction not idle outside sequence");
  capture_shift_a: assert property (dr_capture |=> dr_shift && !dr_capture)
    else $error("capture not followed by shift");
  shift_len_a: assert property ($fell(dr_shift) |-> shift_cnt == 6'h20 && dr_update)
    else $error("shift run not 32 cycles then update");
  strobe_single_a: assert property ($onehot0({dr_capture, dr_shift, dr_update}))
    else $error("sequence strobes overlap");
  update_once_a: assert property (dr_update |=> !seq_on)
    else $error("update not followed by idle");
  pulse_len_a: assert property ($fell(reconfig_request_n) |->
      (!reconfig_request_n)[*8] ##1 !reconfig_request_n ##1 !reconfig_request_n
      ##1 reconfig_request_n)
    else $error("reconfiguration pulse not 10 cycles");
  error_reset_a: assert property (!reconfig_request_n |=> !crc_error && config_status_n)
    else $error("reconfiguration did not restart checking");
  status_hold_a: assert property (!config_status_n && reconfig_request_n |=> !config_status_n)
    else $error("configuration status released without restart");
  unconf_quiet_a: assert property (!config_status_n |-> !crc_error)
    else $error("error raised while configuration failed");

  // Main scenarios reached
  cover property (dr_update);
  cover property ($fell(reconfig_request_n));
  cover property ($fell(config_status_n));
  cover property ($rose(crc_error));
endmodule

// file: tb/config_memory_crc_checker_tb.sv
// Bench: checking device and test controller joined over the link
// Assumes the map header and package are compiled first; one clock domain
`timescale 1ns/1ns
`include "crc_checker_map.svh"
module config_memory_crc_checker_tb
  import crc_checker_pkg::*;
;
  logic core_clk, rst_n, cfg_valid, single_event_upset, avs_read, avs_write;
  logic in_user_mode, avs_waitrequest, irq;
  logic [`WORD_MSB:0] cfg_data, avs_writedata, last_signature, avs_readdata;
  logic [`CELL_AW-1:0] upset_addr;
  logic [`BIT_AW-1:0] upset_bit;
  logic [`ADDR_MSB:0] avs_address;
  logic [31:0] cells [0:63];  // Bench copy of the cell array
  logic [31:0] ref_crc, got;
  int num_errors, total_checks;

  crc_link_if link ();
  config_memory_crc_checker config_memory_crc_checker_i (.core_clk(core_clk), .rst_n(rst_n),
    .cfg_valid(cfg_valid), .cfg_data(cfg_data), .single_event_upset(single_event_upset),
    .upset_addr(upset_addr), .upset_bit(upset_bit), .in_user_mode(in_user_mode),
    .last_signature(last_signature), .link(link));
  crc_test_controller crc_test_controller_i (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link(link));
  crc_link_assertions crc_link_assertions_i (.core_clk(core_clk), .rst_n(rst_n),
    .reconfig_request_n(link.reconfig_request_n), .instr(link.instr),
    .dr_capture(link.dr_capture), .dr_shift(link.dr_shift), .dr_update(link.dr_update),
    .tdi(link.tdi), .tdo(link.tdo), .crc_error(link.crc_error),
    .config_status_n(link.config_status_n));
  // Second device built without the scrubber; its link only follows restarts
  crc_link_if link_off ();
  assign {link_off.reconfig_request_n, link_off.instr, link_off.dr_capture, link_off.dr_shift,
    link_off.dr_update, link_off.tdi} = {link.reconfig_request_n, 14'h0000};
  config_memory_crc_checker #(.CHECK_ENABLE(1'b0)) config_memory_crc_checker_off_i (.core_clk,
    .rst_n, .cfg_valid, .cfg_data, .single_event_upset, .upset_addr, .upset_bit,
    .in_user_mode(), .last_signature(), .link(link_off));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Frame check value, MSB first over four data words
  function automatic logic [15:0] crc16(input int base);
    logic [15:0] c;
    c = `CRC16_INIT;
    for (int i = 0; i < 128; i++) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ cells[base + i / 32][31 - i % 32]) ? `CRC16_POLY : 16'h0);
    end
    return c;
  endfunction

  // Whole-array check value over all 64 words
  function automatic logic [31:0] crc32();
    logic [31:0] c;
    c = `CRC32_INIT;
    for (int i = 0; i < 2048; i++) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ cells[i / 32][31 - i % 32]) ? `CRC32_POLY : 32'h0);
    end
    return c;
  endfunction

  task automatic check_word(input logic [31:0] exp, input logic [31:0] act);
    total_checks++;
    if (act !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  task automatic check_bit(input logic exp, input logic act);
    check_word({31'h0, exp}, {31'h0, act});
  endtask

  // One bus cycle; held until waitrequest is seen low at an edge
  task automatic av_access(input logic rd, input logic [2:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= addr;
    avs_writedata <= wd;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    got = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      num_errors++;
    end
  endtask

  task automatic wr(input logic [2:0] addr, input logic [31:0] wd);
    av_access(1'b0, addr, wd);
  endtask

  task automatic rd_chk(input logic [2:0] addr, input logic [31:0] exp);
    av_access(1'b1, addr, 32'h0);
    check_word(exp, got);
  endtask

  // Poll busy; the link sequence is about 35 cycles
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      av_access(1'b1, `REG_STATUS, 32'h0);
      n++;
    end while (got[0] !== 1'b0 && n < 40);
  endtask

  task automatic send_word(input logic [31:0] w);
    @(posedge core_clk);
    cfg_valid <= 1'b1;
    cfg_data <= w;
  endtask

  // Full stream; frame bad_frame gets a corrupted check value
  task automatic load_config(input int bad_frame);
    logic [15:0] fc;
    for (int f = 0; f < 16; f++) begin
      for (int w = 0; w < 4; w++) begin
        send_word(cells[f * 4 + w]);
      end
      fc = crc16(f * 4);
      if (f == bad_frame) begin
        fc = fc ^ 16'h0001;
      end
      send_word({16'h0000, fc});
    end
    send_word(ref_crc);
    @(posedge core_clk);
    cfg_valid <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog; the tests need about 1000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end

  initial begin
    {rst_n, cfg_valid, single_event_upset, avs_read, avs_write} = 5'h00;
    {cfg_data, avs_writedata, avs_address} = '0;
    upset_addr = 6'h05;
    upset_bit = 5'h03;
    num_errors = 0;
    total_checks = 0;
    for (int i = 0; i < 64; i++) begin
      cells[i] = (32'h9E3779B9 * i) ^ 32'h00FF00FF;
    end
    ref_crc = crc32();
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    // Clean load, then passes must match
    load_config(99);
    repeat (2) @(posedge core_clk);
    check_bit(1'b1, in_user_mode);
    check_bit(1'b1, link.config_status_n);
    repeat (140) @(posedge core_clk);
    check_word(32'h0, last_signature);
    check_bit(1'b0, link.crc_error);
    rd_chk(`REG_STATUS, 32'h4);
    rd_chk(3'h7, 32'h0);
    wr(`REG_IRQ_MASK, 32'h7);
    rd_chk(`REG_IRQ_MASK, 32'h7);
    $display("test clean_load done");
    // Inject a wrong reference, then restore it with the event masked
    wr(`REG_BAD_VALUE, 32'hDEADBEEF);
    wr(`REG_CTRL, 32'h1);
    wait_idle();
    rd_chk(`REG_SAVED, ref_crc);
    repeat (140) @(posedge core_clk);
    check_bit(1'b1, link.crc_error);
    check_word(ref_crc ^ 32'hDEADBEEF, last_signature);
    rd_chk(`REG_STATUS, 32'hE);
    rd_chk(`REG_IRQ_STATUS, 32'h3);
    check_bit(1'b1, irq);
    wr(`REG_IRQ_STATUS, 32'h1);
    rd_chk(`REG_IRQ_STATUS, 32'h2);
    wr(`REG_IRQ_STATUS, 32'h2);
    rd_chk(`REG_IRQ_STATUS, 32'h0);
    check_bit(1'b0, irq);
    wr(`REG_IRQ_MASK, 32'h0);
    wr(`REG_CTRL, 32'h2);
    wait_idle();
    repeat (140) @(posedge core_clk);
    check_bit(1'b0, link.crc_error);
    check_word(32'h0, last_signature);
    rd_chk(`REG_IRQ_STATUS, 32'h2);
    check_bit(1'b0, irq);
    wr(`REG_IRQ_MASK, 32'h2);
    @(posedge core_clk);
    check_bit(1'b1, irq);
    wr(`REG_IRQ_STATUS, 32'h7);
    wr(`REG_IRQ_MASK, 32'h7);
    $display("test inject_restore done");
    // Flip one cell, then restart from the controller
    @(posedge core_clk);
    single_event_upset <= 1'b1;
    @(posedge core_clk);
    single_event_upset <= 1'b0;
    cells[5][3] = ~cells[5][3];
    repeat (140) @(posedge core_clk);
    check_bit(1'b1, link.crc_error);
    check_word(crc32() ^ ref_crc, last_signature);
    check_bit(1'b0, link_off.crc_error);
    cells[5][3] = ~cells[5][3];
    wr(`REG_CTRL, 32'h4);
    repeat (15) @(posedge core_clk);
    check_bit(1'b0, in_user_mode);
    check_bit(1'b0, link.crc_error);
    $display("test upset_reconfig done");
    // Corrupt frame 2: load stops, later words and link loads ignored
    load_config(2);
    repeat (2) @(posedge core_clk);
    check_bit(1'b0, link.config_status_n);
    check_bit(1'b0, in_user_mode);
    rd_chk(`REG_IRQ_STATUS, 32'h5);
    check_bit(1'b1, irq);
    wr(`REG_CTRL, 32'h1);
    wait_idle();
    rd_chk(`REG_SAVED, 32'h0);
    check_bit(1'b0, link.crc_error);
    $display("test bad_frame done");
    complete_run();
  end
endmodule
